//--- core/scpc_consts.svh
// Offsets, field positions, reset values and counts for the shading corrector pin control.
`ifndef SCPC_CONSTS_SVH
`define SCPC_CONSTS_SVH
`define SCPC_OFS_STATUS 8'h00
`define SCPC_OFS_INDEX 8'h04
`define SCPC_OFS_POSITION 8'h08
`define SCPC_OFS_TIMING 8'h0c
`define SCPC_INDEX_RST 8'h00
`define SCPC_SRAM_WORDS 8'hd0
`define SCPC_TIMING_BYTES 8'h0a
`define SCPC_TIMING_RST 8'h00
`define SCPC_FLIP_SUB 4'h8
`define SCPC_VFLIP_BIT 4
`define SCPC_HFLIP_BIT 3
`define SCPC_MAIN_TIMING_BIT 3
`define SCPC_SYNC_BITS 13
`define SCPC_SYNC_RST 13'h0000
`define SCPC_PIN_HALVE 0
`define SCPC_PIN_SRC 1
`define SCPC_PIN_VFLIP 2
`define SCPC_PIN_HFLIP 3
`define SCPC_PIN_LIMITER 4
`define SCPC_PIN_CLEAR_N 5
`define SCPC_PIN_VSTART 6
`define SCPC_PIN_HSYNC 7
`define SCPC_PIN_STROBE 8
`define SCPC_PIN_SCLK 9
`define SCPC_PIN_SER_DATA 10
`define SCPC_PIN_CONV_CLK 11
`define SCPC_PIN_HSTART 12
`endif

//--- core/scpc_pkg.sv
// Types shared by the shading corrector pin control modules.
package scpc_pkg;
    typedef enum logic [3:0] {
        SCPC_SER_IDLE = 4'b0001,
        SCPC_SER_MAIN = 4'b0010,
        SCPC_SER_SUB = 4'b0100,
        SCPC_SER_DATA = 4'b1000
    } scpc_ser_state_t;
    typedef logic [5:0] scpc_word_t;
endpackage

//--- core/scpc_serial_rx.sv
// Three-wire serial receiver producing addressed byte writes.
`include "scpc_consts.svh"
module scpc_serial_rx
    import scpc_pkg::*;
(
    // Clock and control.
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic tick_in,
    input wire logic clear_in,
    // Filtered serial pins.
    input wire logic strobe_in,
    input wire logic sclk_in,
    input wire logic data_bit_in,
    // Write port.
    output logic wr_out,
    output logic [3:0] mask_out,
    output logic [7:0] addr_out,
    output logic [7:0] data_out,
    output logic busy_out
);
    scpc_ser_state_t state_reg, state_next;
    logic sclk_prev_reg;
    logic [2:0] bit_reg;
    logic [7:0] shift_reg;
    wire logic rise = sclk_in & ~sclk_prev_reg;
    wire logic [7:0] byte_now = {shift_reg[6:0], data_bit_in};
    wire logic byte_done = rise & ~strobe_in & (bit_reg == 3'h7);

    // A frame is a strobe-low window; the first byte names blocks, the second the start.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SCPC_SER_IDLE: if (!strobe_in) state_next = SCPC_SER_MAIN;
            SCPC_SER_MAIN: if (strobe_in) state_next = SCPC_SER_IDLE;
                else if (byte_done) state_next = SCPC_SER_SUB;
            SCPC_SER_SUB: if (strobe_in) state_next = SCPC_SER_IDLE;
                else if (byte_done) state_next = SCPC_SER_DATA;
            SCPC_SER_DATA: if (strobe_in) state_next = SCPC_SER_IDLE;
            default: state_next = SCPC_SER_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || clear_in) begin
            state_reg <= SCPC_SER_IDLE;
            sclk_prev_reg <= 1'b0;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            wr_out <= 1'b0;
            mask_out <= 4'h0;
            addr_out <= 8'h00;
            data_out <= 8'h00;
        end else if (tick_in) begin
            state_reg <= state_next;
            sclk_prev_reg <= sclk_in;
            wr_out <= byte_done && state_reg == SCPC_SER_DATA;
            if (strobe_in) begin
                bit_reg <= 3'h0;
            end else if (rise) begin
                bit_reg <= bit_reg + 3'h1;
                shift_reg <= byte_now;
            end
            if (byte_done) begin
                case (state_reg)
                    SCPC_SER_MAIN: mask_out <= byte_now[3:0];
                    SCPC_SER_SUB: addr_out <= byte_now;
                    SCPC_SER_DATA: data_out <= byte_now;
                    default: data_out <= data_out;
                endcase
            end
            if (wr_out) begin
                addr_out <= addr_out + 8'h01;
            end
        end
    end

    assign busy_out = (state_reg != SCPC_SER_IDLE);
endmodule

//--- core/scpc_top.sv
// Pin control top: clock halving, scan inversion, output limiter, converter clock, clear.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`include "scpc_consts.svh"
// How it works
// - Internal clock halves when halving select high.
// - Flip input high means normal scan.
// - Pin flip levels ignored in register mode.
// - Limiter low drives digital correction words out.
// - Limiter high floats all eighteen outputs.
// - Converter clock generated inside, driven out.
// - Clear low restores configuration defaults.
// - Vertical start and hsync are timing references.
// - Settings load only through serial port.
// - Serial bytes: main address, sub address, data.
// - Write address increments after each byte.
module scpc_top
    import scpc_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // Wishbone slave.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Clock and clear pins.
    input wire logic clock_halving_select_in,
    input wire logic system_clear_n_in,
    // Scan inversion pins.
    input wire logic flip_source_select_in,
    input wire logic vertical_flip_in,
    input wire logic horizontal_flip_in,
    // Timing references.
    input wire logic vertical_start_pulse_in,
    input wire logic horizontal_start_pulse_in,
    input wire logic horizontal_sync_in,
    // Serial control port.
    input wire logic serial_strobe_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    // Converter and digital outputs.
    input wire logic output_limiter_in,
    input wire logic converter_clock_in,
    output logic converter_clock_out,
    output logic [17:0] converter_data_out,
    output logic [17:0] digital_correction_out,
    output logic [17:0] digital_correction_oe_out
);
    logic [`SCPC_SYNC_BITS-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
    logic [`SCPC_SYNC_BITS-1:0] pin_prev_reg;
    logic phase_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] index_reg;
    logic [15:0] pixel_reg, line_reg;
    logic dack_reg;
    logic [17:0] word_reg, latched_reg;
    scpc_word_t sram0 [0:207];
    scpc_word_t sram1 [0:207];
    scpc_word_t sram2 [0:207];
    logic [7:0] timing_reg [0:9];
    logic ser_wr, ser_busy;
    logic [3:0] ser_mask;
    logic [7:0] ser_addr, ser_data;

    function automatic logic rising(input logic now, input logic prev);
        rising = now & ~prev;
    endfunction

    wire logic [`SCPC_SYNC_BITS-1:0] pins_raw = {horizontal_start_pulse_in,
        converter_clock_in, serial_data_in, serial_clock_in, serial_strobe_in,
        horizontal_sync_in, vertical_start_pulse_in, system_clear_n_in,
        output_limiter_in, horizontal_flip_in, vertical_flip_in,
        flip_source_select_in, clock_halving_select_in};
    // A pin counts as changed only once the second and third stages agree.
    wire logic [`SCPC_SYNC_BITS-1:0] agree = ~(s2_reg ^ s3_reg);
    wire logic [`SCPC_SYNC_BITS-1:0] pin_next = (agree & s3_reg) | (~agree & pin_reg);
    wire logic clear_act = ~pin_reg[`SCPC_PIN_CLEAR_N];
    wire logic halve = pin_reg[`SCPC_PIN_HALVE];
    // The halved clock is an enable on clk_in, so no second clock tree is built.
    wire logic tick = clk_en_in & (~halve | phase_reg);
    wire logic use_pins = pin_reg[`SCPC_PIN_SRC];
    wire logic [7:0] flip_byte = timing_reg[`SCPC_FLIP_SUB];
    // Pin levels reach the scan controls only through the select.
    wire logic v_normal = use_pins ? pin_reg[`SCPC_PIN_VFLIP]
        : flip_byte[`SCPC_VFLIP_BIT];
    wire logic h_normal = use_pins ? pin_reg[`SCPC_PIN_HFLIP]
        : flip_byte[`SCPC_HFLIP_BIT];
    wire logic hs_edge = rising(pin_reg[`SCPC_PIN_HSYNC], pin_prev_reg[`SCPC_PIN_HSYNC]);
    wire logic vs_edge = rising(pin_reg[`SCPC_PIN_VSTART], pin_prev_reg[`SCPC_PIN_VSTART]);
    wire logic dk_edge = rising(pin_reg[`SCPC_PIN_CONV_CLK], pin_prev_reg[`SCPC_PIN_CONV_CLK]);
    wire logic sram_idx_ok = (index_reg < `SCPC_SRAM_WORDS);
    wire logic [17:0] sram_word = sram_idx_ok ? {sram2[index_reg], sram1[index_reg],
        sram0[index_reg]} : 18'h00000;
    wire logic ser_sram_ok = ser_wr && (ser_addr < `SCPC_SRAM_WORDS);
    wire logic ser_tim_ok = ser_wr && ser_mask[`SCPC_MAIN_TIMING_BIT]
        && (ser_addr < `SCPC_TIMING_BYTES);
    wire logic [3:0] tim_sel = index_reg[3:0];
    wire logic [7:0] tim_read = (tim_sel < 4'ha) ? timing_reg[tim_sel] : 8'h00;
    // Status reports normal-scan levels; low in bit 0 or 1 means reverse scan.
    wire logic [31:0] status_word = {24'h000000, phase_reg, ser_busy, clear_act,
        pin_reg[`SCPC_PIN_LIMITER], halve, use_pins, h_normal, v_normal};
    wire logic bus_req = wb_cyc_in & wb_stb_in;
    wire logic bus_write = bus_req & wb_we_in & ack_reg & clk_en_in;
    wire logic [31:0] read_mux = (wb_adr_in == `SCPC_OFS_STATUS) ? status_word
        : (wb_adr_in == `SCPC_OFS_INDEX) ? {24'h000000, index_reg}
        : (wb_adr_in == `SCPC_OFS_POSITION) ? {line_reg, pixel_reg}
        : (wb_adr_in == `SCPC_OFS_TIMING) ? {24'h000000, tim_read}
        : 32'h00000000;

    // Pin synchronisers run on the undivided clock so the select itself is clean.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_reg <= `SCPC_SYNC_RST;
            s2_reg <= `SCPC_SYNC_RST;
            s3_reg <= `SCPC_SYNC_RST;
            pin_reg <= `SCPC_SYNC_RST;
        end else if (clk_en_in) begin
            s1_reg <= pins_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || clear_act) begin
            phase_reg <= 1'b0;
        end else if (clk_en_in) begin
            phase_reg <= ~phase_reg;
        end
    end

    // Wishbone slave: one wait state, ack drops the cycle after it is given.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
            index_reg <= `SCPC_INDEX_RST;
        end else if (clk_en_in) begin
            ack_reg <= bus_req & ~ack_reg;
            if (bus_req && !ack_reg) begin
                dat_reg <= read_mux;
            end
            if (bus_write && wb_adr_in == `SCPC_OFS_INDEX && wb_sel_in[0]) begin
                index_reg <= wb_dat_in[7:0];
            end
        end
    end

    // Serially loaded configuration; clear restores the defaults.
    always_ff @(posedge clk_in) begin
        if (srst_in || clear_act) begin
            for (int i = 0; i < 10; i++) begin
                timing_reg[i] <= `SCPC_TIMING_RST;
            end
        end else if (tick && ser_tim_ok) begin
            timing_reg[ser_addr[3:0]] <= ser_data;
        end
    end

    // Correction memories are not cleared; software reloads them after power-on.
    always_ff @(posedge clk_in) begin
        if (tick && ser_sram_ok) begin
            if (ser_mask[0]) sram0[ser_addr] <= ser_data[5:0];
            if (ser_mask[1]) sram1[ser_addr] <= ser_data[5:0];
            if (ser_mask[2]) sram2[ser_addr] <= ser_data[5:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in || clear_act) begin
            pin_prev_reg <= `SCPC_SYNC_RST;
            pixel_reg <= 16'h0000;
            line_reg <= 16'h0000;
            dack_reg <= 1'b0;
            word_reg <= 18'h00000;
            latched_reg <= 18'h00000;
        end else if (tick) begin
            pin_prev_reg <= pin_reg;
            pixel_reg <= hs_edge ? 16'h0000 : pixel_reg + 16'h0001;
            if (vs_edge) begin
                line_reg <= 16'h0000;
            end else if (hs_edge) begin
                line_reg <= line_reg + 16'h0001;
            end
            dack_reg <= ~dack_reg;
            word_reg <= sram_word;
            if (dk_edge) begin
                latched_reg <= word_reg;
            end
        end
    end

    scpc_serial_rx u_serial_rx (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_in(tick),
        .clear_in(clear_act),
        .strobe_in(pin_reg[`SCPC_PIN_STROBE]),
        .sclk_in(pin_reg[`SCPC_PIN_SCLK]),
        .data_bit_in(pin_reg[`SCPC_PIN_SER_DATA]),
        .wr_out(ser_wr),
        .mask_out(ser_mask),
        .addr_out(ser_addr),
        .data_out(ser_data),
        .busy_out(ser_busy)
    );

    assign wb_ack_out = ack_reg;
    assign wb_dat_out = dat_reg;
    assign converter_clock_out = dack_reg;
    assign converter_data_out = latched_reg;
    assign digital_correction_out = word_reg;
    assign digital_correction_oe_out = {18{~pin_reg[`SCPC_PIN_LIMITER]}};
endmodule

//--- sim/scpc_chk.sv
// Port checker for the shading corrector pin control.
module scpc_chk (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic clk_en_in,
    // Bus handshake.
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    // Pins.
    input wire logic clock_halving_select_in,
    input wire logic system_clear_n_in,
    input wire logic output_limiter_in,
    input wire logic converter_clock_out,
    input wire logic [17:0] digital_correction_oe_out
);
    logic [3:0] pins_reg;
    logic [3:0] calm_reg;
    wire logic [3:0] pins_now = {clk_en_in, clock_halving_select_in, system_clear_n_in,
        output_limiter_in};
    // Pins are judged only once they have had time to pass the synchroniser.
    always_ff @(posedge clk_in) begin
        pins_reg <= pins_now;
        if (srst_in || pins_now != pins_reg) begin
            calm_reg <= 4'h0;
        end else if (calm_reg != 4'hf) begin
            calm_reg <= calm_reg + 4'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // A pin that changes at this very edge has not yet passed the synchroniser.
    sequence settled_s;
        calm_reg >= 4'h8 && pins_now == pins_reg;
    endsequence
    sequence halving_s;
        settled_s ##0 (clock_halving_select_in && system_clear_n_in);
    endsequence
    sequence full_s;
        settled_s ##0 (!clock_halving_select_in && system_clear_n_in);
    endsequence
    sequence bus_req_s;
        wb_cyc_in && wb_stb_in && !wb_ack_out && clk_en_in;
    endsequence
    ack_time_a: assert property (bus_req_s ##1 clk_en_in |-> wb_ack_out)
        else $error("bus ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack longer than one cycle");
    reset_quiet_a: assert property ($fell(srst_in) |-> !wb_ack_out && !converter_clock_out)
        else $error("outputs not quiet after reset");
    halve_rate_a: assert property (halving_s ##0 $changed(converter_clock_out)
        |=> $stable(converter_clock_out))
        else $error("converter clock too fast when halving");
    halve_live_a: assert property (halving_s
        |-> ##[1:2] $changed(converter_clock_out))
        else $error("converter clock stalled when halving");
    full_rate_a: assert property (full_s |=> $changed(converter_clock_out))
        else $error("converter clock not at full rate");
    clear_hold_a: assert property (settled_s ##0 !system_clear_n_in
        |-> $stable(converter_clock_out))
        else $error("divider moved during clear");
    limiter_float_a: assert property (settled_s ##0 output_limiter_in
        |-> digital_correction_oe_out == 18'h0)
        else $error("outputs driven while limited");
    limiter_drive_a: assert property (settled_s ##0 !output_limiter_in
        |-> digital_correction_oe_out == 18'h3ffff)
        else $error("outputs floating while enabled");
endmodule
bind scpc_top scpc_chk i_chk (.clk_in, .srst_in, .clk_en_in, .wb_cyc_in, .wb_stb_in,
    .wb_ack_out, .clock_halving_select_in, .system_clear_n_in, .output_limiter_in,
    .converter_clock_out, .digital_correction_oe_out);

//--- sim/scpc_host.sv
// Timing generator and serial host model driving the corrector's input pins.
module scpc_host (
    // Clock.
    input wire logic clk_in,
    // Serial control port.
    output logic strobe_out = 1'b1,
    output logic sclk_out = 1'b1,
    output logic data_out = 1'b0,
    // Timing references.
    output logic vstart_out = 1'b0,
    output logic hsync_out = 1'b0,
    output logic hstart_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] pix_reg = 6'h00;
    logic [3:0] line_reg = 4'h0;
    // Pulse eliminator display is not used, so the start pulse stays high.
    assign hstart_out = 1'b1;
    // Vertical start rises 20 clocks after the sync front edge, once every 16 lines.
    always @(posedge clk_in) begin
        pix_reg <= pix_reg + 6'h01;
        line_reg <= line_reg + {3'h0, pix_reg == 6'h3f};
        hsync_out <= pix_reg < 6'h08;
        vstart_out <= line_reg == 4'h0 && pix_reg >= 6'h14 && pix_reg < 6'h1c;
    end
    // Four bytes a frame, MSB first; slow edges leave room for the pin synchroniser.
    task automatic send(input logic [31:0] w);
        @(posedge clk_in);
        strobe_out <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            repeat (20) @(posedge clk_in);
            sclk_out <= 1'b0;
            data_out <= w[i];
            repeat (20) @(posedge clk_in);
            sclk_out <= 1'b1;
        end
        repeat (20) @(posedge clk_in);
        strobe_out <= 1'b1;
        data_out <= ~w[0];
    endtask
endmodule

//--- sim/scpc_top_bench.sv
// Self-checking bench for the shading corrector pin control.
module scpc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, srst_in = 1'b1, clk_en_in = 1'b1, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0, clock_halving_select_in = 1'b1, system_clear_n_in = 1'b1;
    logic flip_source_select_in = 1'b1, vertical_flip_in = 1'b1, horizontal_flip_in = 1'b1;
    logic output_limiter_in = 1'b1, wb_ack_out, converter_clock_out;
    logic vertical_start_pulse_in, horizontal_start_pulse_in, horizontal_sync_in;
    logic serial_strobe_in, serial_clock_in, serial_data_in;
    logic [3:0] wb_sel_in = 4'h1;
    logic [7:0] wb_adr_in = 8'h00, a;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd, rnd = 32'h3d02;
    logic [17:0] digital_correction_out, digital_correction_oe_out, converter_data_out;
    int error_cnt = 0, comparisons = 0;
    always #4 clk_in = ~clk_in;
    scpc_host i_host (.clk_in, .strobe_out(serial_strobe_in), .sclk_out(serial_clock_in),
        .data_out(serial_data_in), .vstart_out(vertical_start_pulse_in),
        .hsync_out(horizontal_sync_in), .hstart_out(horizontal_start_pulse_in));
    scpc_top i_dut (.clk_in, .srst_in, .clk_en_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
        .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .clock_halving_select_in,
        .system_clear_n_in, .flip_source_select_in, .vertical_flip_in, .horizontal_flip_in,
        .vertical_start_pulse_in, .horizontal_start_pulse_in, .horizontal_sync_in,
        .serial_strobe_in, .serial_clock_in, .serial_data_in, .output_limiter_in,
        .converter_clock_in(converter_clock_out),
        .converter_clock_out, .converter_data_out, .digital_correction_out,
        .digital_correction_oe_out);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [17:0] exp_word(input logic [7:0] b);
        return {3{b[5:0]}};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The master waits for ack however long it takes; only the watchdog ends a hang.
    task automatic wb(input logic w, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= adr;
        wb_sel_in <= 4'h1;
        wb_dat_in <= dat;
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask
    task automatic end_sim;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            flip_source_select_in <= 1'b0;
            vertical_flip_in <= rnd[0];
            horizontal_flip_in <= rnd[1];
            i_host.send({8'h08, 8'h08, rnd[15:8], 8'h00});
            repeat (10) @(posedge clk_in);
            wb(1'b0, 8'h00, 32'h0);
            check("flip serial", 32'(rd[2:0]), 32'({1'b0, rnd[11], rnd[12]}));
            flip_source_select_in <= 1'b1;
            repeat (10) @(posedge clk_in);
            wb(1'b0, 8'h00, 32'h0);
            check("flip pins", 32'(rd[2:0]), 32'({1'b1, rnd[1], rnd[0]}));
            wb(1'b1, 8'h04, 32'h8);
            wb(1'b0, 8'h0c, 32'h0);
            check("timing byte", rd, {24'h0, rnd[15:8]});
        end
        $display("test flip done");
        rnd = lfsr(rnd);
        a = {1'b0, rnd[6:0]};
        i_host.send({8'h07, a, rnd[15:8], rnd[23:16]});
        wb(1'b1, 8'h04, {24'h0, a + 8'h01});
        output_limiter_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        check("word next", 32'(digital_correction_out), 32'(exp_word(rnd[23:16])));
        check("enables", 32'(digital_correction_oe_out), 32'h3ffff);
        wb(1'b1, 8'h04, {24'h0, a});
        repeat (12) @(posedge clk_in);
        check("word first", 32'(digital_correction_out), 32'(exp_word(rnd[15:8])));
        output_limiter_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        check("floating", 32'(digital_correction_oe_out), 32'h0);
        check("converter word", 32'(converter_data_out), 32'(exp_word(rnd[15:8])));
        wb(1'b0, 8'h08, 32'h0);
        // Sixteen sync edges fall between two vertical starts, so line 16 is legal.
        check("position", 32'(rd[15:0] < 16'h0040 && rd[31:16] < 16'h0011), 32'h1);
        $display("test memory done");
        clock_halving_select_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        wb(1'b0, 8'h00, 32'h0);
        check("halving off", 32'(rd[3]), 32'h0);
        clk_en_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rd = 32'(converter_clock_out);
        repeat (3) @(posedge clk_in);
        check("frozen clock", 32'(converter_clock_out), rd);
        clk_en_in <= 1'b1;
        clock_halving_select_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        wb(1'b0, 8'h00, 32'h0);
        check("halving on", 32'(rd[3]), 32'h1);
        $display("test halving done");
        wb(1'b1, 8'h04, 32'h8);
        system_clear_n_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        wb(1'b0, 8'h00, 32'h0);
        check("clear flag", 32'(rd[5]), 32'h1);
        system_clear_n_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        wb(1'b0, 8'h0c, 32'h0);
        check("cleared byte", rd, 32'h0);
        $display("test clear done");
        wb(1'b1, 8'h20, lfsr(rnd));
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        check("index kept", rd, 32'h8);
        $display("test bus done");
        end_sim();
    end
endmodule
